// ### aab_exec.sv
// Behaviour
// - opcode 1110: acc and literal into acc
// - register and, d=0 result to acc
// - register and, d=1 result to file
// - bit clear, other bits and flags kept
// - bit set, other bits and flags kept
// - bit test skip next when zero
// - file address low five, bit above
// - skip replaces next word by no-op
`timescale 1ns/1ps
`include "aab_map.svh"
module aab_exec (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        instr_valid,
  input  wire logic [11:0] instr,
  input  wire logic [7:0]  file_rdata,
  output logic [4:0]       file_addr,
  output logic             file_we,
  output logic [7:0]       file_wdata,
  output logic [7:0]       acc,
  output logic             zero_flag,
  output logic             zero_we,
  output logic             skip_next,
  output logic             slot_nop
);
  typedef struct packed {
    logic [7:0]          acc;
    logic                z;
    logic                zwe;
    logic                we;
    logic [7:0]          wdata;
    logic                skipq;
    aab_pkg::aab_state_t st;
  } aab_state_s_t;

  aab_state_s_t s_q;
  aab_state_s_t s_d;
  aab_dec_if    dif ();

  aab_decode u_dec (
    .instr (instr),
    .d     (dif)
  );

  // bit mask shared by the three bit ops
  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'h01 << b;
  endfunction

  // file address comes straight from decode so the read is same-cycle
  assign file_addr = dif.faddr;

  logic [7:0] and_res;
  logic       exec_ok;
  assign and_res = s_q.acc & ((dif.op == aab_pkg::AAB_OP_ANDLIT) ? dif.lit : file_rdata);
  // the slot after a taken skip is swallowed, whatever word it holds
  assign exec_ok = instr_valid && (s_q.st == aab_pkg::AAB_ST_RUN);

  // next-state computation
  always_comb begin
    s_d       = s_q;
    s_d.we    = 1'b0;
    s_d.zwe   = 1'b0;
    s_d.skipq = 1'b0;
    if (instr_valid && s_q.st == aab_pkg::AAB_ST_SKIP) begin
      s_d.st = aab_pkg::AAB_ST_RUN;
    end
    if (exec_ok) begin
      unique case (dif.op)
        aab_pkg::AAB_OP_ANDLIT: begin
          s_d.acc = and_res;
          s_d.z   = (and_res == 8'h00);
          s_d.zwe = 1'b1;
        end
        aab_pkg::AAB_OP_ANDREG: begin
          if (dif.dest_f) begin
            s_d.we    = 1'b1;
            s_d.wdata = and_res;
          end else begin
            s_d.acc = and_res;
          end
          s_d.z   = (and_res == 8'h00);
          s_d.zwe = 1'b1;
        end
        aab_pkg::AAB_OP_BCLR: begin
          s_d.we    = 1'b1;
          s_d.wdata = file_rdata & ~bit_mask(dif.bsel);
        end
        aab_pkg::AAB_OP_BSET: begin
          s_d.we    = 1'b1;
          s_d.wdata = file_rdata | bit_mask(dif.bsel);
        end
        aab_pkg::AAB_OP_BTSK: begin
          if ((file_rdata & bit_mask(dif.bsel)) == 8'h00) begin
            s_d.skipq = 1'b1;
            s_d.st    = aab_pkg::AAB_ST_SKIP;
          end
        end
        aab_pkg::AAB_OP_NONE: begin
        end
      endcase
    end
  end

  // single state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q <= '{acc: `AAB_ACC_RST, z: `AAB_Z_RST, zwe: 1'b0, we: 1'b0,
               wdata: 8'h00, skipq: 1'b0, st: aab_pkg::AAB_ST_RUN};
    end else begin
      s_q <= s_d;
    end
  end

  // write port is registered: the file sees the write one edge later
  assign file_we    = s_q.we;
  assign file_wdata = s_q.wdata;
  assign acc        = s_q.acc;
  assign zero_flag  = s_q.z;
  assign zero_we    = s_q.zwe;
  assign skip_next  = s_q.skipq;
  assign slot_nop   = instr_valid && (s_q.st == aab_pkg::AAB_ST_SKIP);

  // checks
  property p_andlit;
    @(posedge mclk) disable iff (srst)
      (exec_ok && dif.op == aab_pkg::AAB_OP_ANDLIT) |=> (acc == $past(and_res) && zero_we);
  endproperty
  a_andlit: assert property (p_andlit) else $error("literal and wrong");
  property p_andw;
    @(posedge mclk) disable iff (srst)
      (exec_ok && dif.op == aab_pkg::AAB_OP_ANDREG && !dif.dest_f) |=> (!file_we && acc == $past(and_res));
  endproperty
  a_andw: assert property (p_andw) else $error("and to acc wrong");
  property p_andf;
    @(posedge mclk) disable iff (srst)
      (exec_ok && dif.op == aab_pkg::AAB_OP_ANDREG && dif.dest_f) |=> (file_we && $stable(acc));
  endproperty
  a_andf: assert property (p_andf) else $error("and to file wrong");
  property p_bclr;
    @(posedge mclk) disable iff (srst)
      (exec_ok && dif.op == aab_pkg::AAB_OP_BCLR) |=>
        (file_we && !zero_we && file_wdata == ($past(file_rdata) & ~bit_mask($past(dif.bsel))));
  endproperty
  a_bclr: assert property (p_bclr) else $error("bit clear wrong");
  property p_bset;
    @(posedge mclk) disable iff (srst)
      (exec_ok && dif.op == aab_pkg::AAB_OP_BSET) |=>
        (file_we && !zero_we && file_wdata == ($past(file_rdata) | bit_mask($past(dif.bsel))));
  endproperty
  a_bset: assert property (p_bset) else $error("bit set wrong");
  property p_skip;
    @(posedge mclk) disable iff (srst)
      (exec_ok && dif.op == aab_pkg::AAB_OP_BTSK) |=>
        (skip_next == ($past(file_rdata[dif.bsel]) == 1'b0) && !zero_we && !file_we);
  endproperty
  a_skip: assert property (p_skip) else $error("skip decision wrong");
  property p_zero;
    @(posedge mclk) disable iff (srst)
      zero_we |-> (zero_flag == (($past(and_res)) == 8'h00));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_nop;
    @(posedge mclk) disable iff (srst)
      (skip_next && instr_valid) |-> (slot_nop ##1 (!file_we && !zero_we && $stable(acc)));
  endproperty
  a_nop: assert property (p_nop) else $error("skipped slot executed");
  property p_addr;
    @(posedge mclk) disable iff (srst)
      file_addr == instr[4:0];
  endproperty
  a_addr: assert property (p_addr) else $error("file address field wrong");

  // only the selected bit may differ from the value that was read
  property p_bitpos;
    @(posedge mclk) disable iff (srst)
      (exec_ok && (dif.op == aab_pkg::AAB_OP_BCLR || dif.op == aab_pkg::AAB_OP_BSET)) |=>
        (((file_wdata ^ $past(file_rdata)) & ~bit_mask($past(dif.bsel))) == 8'h00);
  endproperty
  a_bitpos: assert property (p_bitpos) else $error("bit op touched other bits");

  // literal and never reaches the file or the skip logic
  property p_lit_only;
    @(posedge mclk) disable iff (srst)
      (exec_ok && dif.op == aab_pkg::AAB_OP_ANDLIT) |=> (!file_we && !skip_next);
  endproperty
  a_lit_only: assert property (p_lit_only) else $error("literal and had side effects");

  // file destination carries the and result and still updates zero
  property p_andf_data;
    @(posedge mclk) disable iff (srst)
      (exec_ok && dif.op == aab_pkg::AAB_OP_ANDREG && dif.dest_f) |=>
        (file_wdata == $past(and_res) && zero_we);
  endproperty
  a_andf_data: assert property (p_andf_data) else $error("and to file data wrong");

  // bit clear leaves the working register and flags alone
  property p_bclr_keep;
    @(posedge mclk) disable iff (srst)
      (exec_ok && dif.op == aab_pkg::AAB_OP_BCLR) |=> ($stable(acc) && $stable(zero_flag) && !skip_next);
  endproperty
  a_bclr_keep: assert property (p_bclr_keep) else $error("bit clear changed state");

  // bit set leaves the working register and flags alone
  property p_bset_keep;
    @(posedge mclk) disable iff (srst)
      (exec_ok && dif.op == aab_pkg::AAB_OP_BSET) |=> ($stable(acc) && $stable(zero_flag) && !skip_next);
  endproperty
  a_bset_keep: assert property (p_bset_keep) else $error("bit set changed state");

  // the test itself changes nothing but the skip decision
  property p_skip_keep;
    @(posedge mclk) disable iff (srst)
      (exec_ok && dif.op == aab_pkg::AAB_OP_BTSK) |=> ($stable(acc) && $stable(zero_flag));
  endproperty
  a_skip_keep: assert property (p_skip_keep) else $error("bit test changed state");

  // zero flag only moves together with its strobe
  property p_zero_hold;
    @(posedge mclk) disable iff (srst)
      !zero_we |-> $stable(zero_flag);
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("zero flag moved without strobe");

  // exactly one word is swallowed, so the skip costs one extra cycle
  property p_slot_once;
    @(posedge mclk) disable iff (srst)
      slot_nop |=> !slot_nop;
  endproperty
  a_slot_once: assert property (p_slot_once) else $error("more than one slot swallowed");
endmodule

// ### aab_map.svh
`ifndef AAB_MAP_SVH
`define AAB_MAP_SVH
// opcode patterns of the decoded 12-bit word
`define AAB_OPC_ANDLIT_HI  4'he
`define AAB_OPC_ANDREG_HI  6'h05
`define AAB_OPC_BITCLR_HI  4'h4
`define AAB_OPC_BITSET_HI  4'h5
`define AAB_OPC_BTSKIP_HI  4'h6
// field positions
`define AAB_F_LSB          0
`define AAB_F_MSB          4
`define AAB_B_LSB          5
`define AAB_B_MSB          7
`define AAB_D_BIT          5
`define AAB_K_MSB          7
// reset values
`define AAB_ACC_RST        8'h00
`define AAB_Z_RST          1'b0
`endif

// ### aab_pkg.sv
package aab_pkg;
  typedef enum logic [2:0] {
    AAB_OP_NONE   = 3'h0,
    AAB_OP_ANDLIT = 3'h1,
    AAB_OP_ANDREG = 3'h3,
    AAB_OP_BCLR   = 3'h2,
    AAB_OP_BSET   = 3'h6,
    AAB_OP_BTSK   = 3'h7
  } aab_op_t;
  typedef enum logic [0:0] {
    AAB_ST_RUN  = 1'b0,
    AAB_ST_SKIP = 1'b1
  } aab_state_t;
endpackage

// ### aab_dec_if.sv
`timescale 1ns/1ps
interface aab_dec_if;
  aab_pkg::aab_op_t op;
  logic [4:0]       faddr;
  logic [2:0]       bsel;
  logic             dest_f;
  logic [7:0]       lit;
  modport dec (output op, output faddr, output bsel, output dest_f, output lit);
  modport exe (input op, input faddr, input bsel, input dest_f, input lit);
endinterface

// ### aab_decode.sv
`timescale 1ns/1ps
`include "aab_map.svh"
module aab_decode (
  input  wire logic [11:0] instr,
  aab_dec_if.dec           d
);
  // pure decode of the opcode and operand fields
  always_comb begin
    d.faddr  = instr[`AAB_F_MSB:`AAB_F_LSB];
    d.bsel   = instr[`AAB_B_MSB:`AAB_B_LSB];
    d.dest_f = instr[`AAB_D_BIT];
    d.lit    = instr[`AAB_K_MSB:0];
    if (instr[11:8] == `AAB_OPC_ANDLIT_HI) begin
      d.op = aab_pkg::AAB_OP_ANDLIT;
    end else if (instr[11:6] == `AAB_OPC_ANDREG_HI) begin
      d.op = aab_pkg::AAB_OP_ANDREG;
    end else if (instr[11:8] == `AAB_OPC_BITCLR_HI) begin
      d.op = aab_pkg::AAB_OP_BCLR;
    end else if (instr[11:8] == `AAB_OPC_BITSET_HI) begin
      d.op = aab_pkg::AAB_OP_BSET;
    end else if (instr[11:8] == `AAB_OPC_BTSKIP_HI) begin
      d.op = aab_pkg::AAB_OP_BTSK;
    end else begin
      d.op = aab_pkg::AAB_OP_NONE;
    end
  end
endmodule

// ### aab_bench.sv
`timescale 1ns/1ps
module and_and_bit_ops_exec_bench;
  logic        mclk;
  logic        srst;
  logic        instr_valid;
  logic [11:0] instr;
  logic [7:0]  file_rdata;
  logic [4:0]  file_addr;
  logic        file_we;
  logic [7:0]  file_wdata;
  logic [7:0]  acc;
  logic        zero_flag;
  logic        zero_we;
  logic        skip_next;
  logic        slot_nop;
  logic [11:0] w;
  int          error_cnt;
  int          checks;
  integer      seed;
  int          mem [32];
  int          acc_m, e_we, e_wd, e_zwe, e_z, e_skn, skip_m, f, b, r, sel, fv, t, pa;

  aab_exec i_aab_exec (
    .mclk        (mclk),
    .srst        (srst),
    .instr_valid (instr_valid),
    .instr       (instr),
    .file_rdata  (file_rdata),
    .file_addr   (file_addr),
    .file_we     (file_we),
    .file_wdata  (file_wdata),
    .acc         (acc),
    .zero_flag   (zero_flag),
    .zero_we     (zero_we),
    .skip_next   (skip_next),
    .slot_nop    (slot_nop)
  );

  // free running core clock, 50 ns
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task results;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // cut a hang short well after the expected run length
  initial begin
    repeat (3300) @(posedge mclk);
    error_cnt++;
    results;
  end

  // random words against an integer model; file memory answers at the address of the word
  initial begin
    seed = 32'h7c30;
    srst = 1'b1;
    instr_valid = 1'b0;
    instr = 12'h000;
    file_rdata = 8'h00;
    {acc_m, e_we, e_wd, e_zwe, e_z, e_skn, skip_m, pa} = '0;
    for (int i = 0; i < 32; i++) mem[i] = $random(seed) & 255;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    for (int n = 0; n < 3000; n++) begin
      sel = $random(seed) & 7;
      f = $random(seed) & 31;
      b = $random(seed) & 7;
      r = $random(seed) & 255;
      case (sel)
        0: w = {4'he, 8'(r)};
        1, 2: w = {6'h05, 1'(r), 5'(f)};
        3: w = {4'h4, 3'(b), 5'(f)};
        4: w = {4'h5, 3'(b), 5'(f)};
        5: w = {4'h6, 3'(b), 5'(f)};
        default: w = {4'hc, 8'(r)}; // opcode outside this block
      endcase
      fv = mem[w[4:0]];
      @(posedge mclk);
      instr <= w;
      instr_valid <= (sel != 7);
      file_rdata <= 8'(fv);
      @(negedge mclk);
      check(8'(file_we), 8'(e_we));
      if (e_we != 0) check(file_wdata, 8'(e_wd));
      check(8'(zero_we), 8'(e_zwe));
      check(8'(zero_flag), 8'(e_z));
      check(8'(skip_next), 8'(e_skn));
      check(acc, 8'(acc_m));
      check(8'(slot_nop), 8'(sel != 7 && skip_m != 0));
      check(8'(file_addr), 8'(w[4:0]));
      // model's own write lands after the read of this cycle, so no forwarding
      if (e_we != 0) mem[pa] = e_wd;
      {e_we, e_zwe, e_skn} = '0;
      if (sel != 7) begin
        if (skip_m != 0) skip_m = 0;
        else case (sel)
          0: begin
            acc_m = acc_m & r;
            e_zwe = 1;
            e_z = (acc_m == 0);
          end
          1, 2: begin
            t = acc_m & fv;
            e_zwe = 1;
            e_z = (t == 0);
            if (w[5]) begin
              e_we = 1;
              e_wd = t;
            end else acc_m = t;
          end
          3: begin
            e_we = 1;
            e_wd = fv & ~(1 << b) & 255;
          end
          4: begin
            e_we = 1;
            e_wd = fv | (1 << b);
          end
          5: if (((fv >> b) & 1) == 0) begin
            e_skn = 1;
            skip_m = 1;
          end
          default: ;
        endcase
      end
      pa = w[4:0];
    end
    results;
  end
endmodule
